//--- rtl/t2r_pkg.sv
// shared constants, register map and carrier types for the reload timer
package t2r_pkg;

    // register indices; byte address is four times the index
    localparam logic [9:0] T2R_IDX_CONTROL = 10'h0c8;
    localparam logic [9:0] T2R_IDX_COUNT_LO = 10'h0cc;
    localparam logic [9:0] T2R_IDX_COUNT_HI = 10'h0cd;
    localparam logic [9:0] T2R_IDX_IRQ_REQ = 10'h0d0;
    localparam logic [9:0] T2R_IDX_IRQ_EN = 10'h0d1;
    localparam logic [9:0] T2R_IDX_RELOAD = 10'h0d2;
    localparam logic [9:0] T2R_IDX_SYSDIV = 10'h0d3;

    // field positions in the interrupt request and enable registers
    localparam int T2R_POS_OVF_FLAG = 0;
    localparam int T2R_POS_EXT_FLAG = 1;
    localparam int T2R_POS_TIMER_IE = 0;
    localparam int T2R_POS_EXT_IE = 1;

    // values after reset
    localparam logic [7:0] T2R_RST_CONTROL = 8'h00;
    localparam logic [15:0] T2R_RST_COUNT = 16'h0000;
    localparam logic [15:0] T2R_RST_RELOAD = 16'h0000;
    localparam logic [7:0] T2R_RST_SYSDIV = 8'h00;

    // prescaler divide counts, in divided system clock cycles
    localparam logic [4:0] T2R_DIV_HALF = 5'h02;
    localparam logic [4:0] T2R_DIV_TWELVE = 5'h0c;
    localparam logic [4:0] T2R_DIV_TWENTYFOUR = 5'h18;

    // input selection and reload mode codes
    localparam logic [1:0] T2R_IN_STOP = 2'h0;
    localparam logic [1:0] T2R_IN_TIMER = 2'h1;
    localparam logic [1:0] T2R_IN_EVENT = 2'h2;
    localparam logic [1:0] T2R_IN_GATED = 2'h3;
    localparam logic [1:0] T2R_RLD_OVF = 2'h2;
    localparam logic [1:0] T2R_RLD_PIN = 2'h3;

    // bus response codes
    localparam logic [1:0] T2R_RESP_OKAY = 2'h0;
    localparam logic [1:0] T2R_RESP_SLVERR = 2'h2;

    // control register layout, bit 7 first
    typedef struct packed {
        logic prescale_div_select;
        logic prescale_bypass_half;
        logic count_width_select;
        logic reload_mode_hi;
        logic reload_mode_lo;
        logic compare_mode_select;
        logic input_select_hi;
        logic input_select_lo;
    } t2r_ctrl_s;

    // held write request: address index, data and lanes
    typedef struct packed {
        logic [9:0] idx;
        logic [31:0] data;
        logic [3:0] strb;
    } t2r_wreq_s;

endpackage

//--- rtl/t2r_timer.sv
// 16/8-bit reload timer with event, gated and prescaled counting
//
// Contract
// - internal clock divided by 2 when bypass set, else by 12 or 24
// - input selection 00 stops the timer and holds the count
// - input selection 01 counts the prescaled or bypassed internal clock
// - input selection 10 counts falling edges on the external count pin
// - external pin sampled once per machine cycle, edges from samples
// - detected edge increments the count in the next machine cycle
// - input selection 11 counts internal clock only while the pin is high
// - width select 0 gives a 16-bit count, 1 an 8-bit count
// - reload mode 0x off, 10 on overflow, 11 on reload pin fall
// - overflow reload sets overflow flag and loads reload value together
// - pin reload loads the reload value and leaves overflow flag alone
// - reload pin fall sets its flag when its interrupt enable is set
// - pin reload happens whatever the width bit and the enable bit
// - both flags drive one shared timer interrupt request
// - both flags readable as separate bits of the request register
// - count exposed as separate low and high byte registers
// - internal clock is the system clock after the system divider
// - reload value comes only from the compare unit 0 reload register
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
module t2r_timer
    import t2r_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // external pins, synchronous to aclk
    input wire logic external_count_gate_pin,
    input wire logic external_reload_pin,
    // to compare units and interrupt controller
    output logic [15:0] count_value,
    output logic compare_mode_select,
    output logic timer_irq
);

    // the index decode needs the full register index range
    if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr_w
        $error("t2r_timer: ADDR_W must be between 12 and 32");
    end

    // software visible state
    t2r_ctrl_s ctrl_ff;
    logic [15:0] cnt_ff;
    logic [15:0] reload_ff;
    logic [7:0] sysdiv_ff;
    logic ovf_flag_ff;
    logic ext_flag_ff;
    logic timer_ie_ff;
    logic ext_ie_ff;
    logic timer_irq_ff;

    // bus slave state
    logic awready_ff;
    logic wready_ff;
    logic aw_full_ff;
    logic w_full_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    t2r_wreq_s wreq_ff;

    // timing state
    logic [7:0] sdiv_cnt_ff;
    logic [4:0] psc_cnt_ff;
    logic evt_smp_ff;
    logic evt_det_ff;
    logic exr_prev_ff;

    // combinational terms
    logic wr_go, wr_lo, wr_hi, wr_ctrl, wr_irq_req, wr_irq_en;
    logic wr_reload, wr_sysdiv, wr_known, sys_en, int_tick, evt_tick;
    logic inc, width8, ovf, exr_fall, rld_ovf, rld_pin, rd_known;
    logic [1:0] in_sel, rld_mode;
    logic [4:0] psc_limit;
    logic [15:0] inc_val, nxt_cnt;
    logic [31:0] rd_word;
    logic [9:0] rd_idx;

    // outputs straight from flops
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign count_value = cnt_ff;
    assign compare_mode_select = ctrl_ff.compare_mode_select;
    assign timer_irq = timer_irq_ff;

    // write address and data are held separately until both are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            aw_full_ff <= 1'b0;
            wready_ff <= 1'b1;
            w_full_ff <= 1'b0;
            wreq_ff <= '0;
        end else begin
            if (s_axi_awvalid && awready_ff) begin
                awready_ff <= 1'b0;
                aw_full_ff <= 1'b1;
                wreq_ff.idx <= s_axi_awaddr[11:2];
            end
            if (s_axi_wvalid && wready_ff) begin
                wready_ff <= 1'b0;
                w_full_ff <= 1'b1;
                wreq_ff.data <= s_axi_wdata;
                wreq_ff.strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_full_ff <= 1'b0;
                w_full_ff <= 1'b0;
            end
            // reopen only after the response is taken: one write in flight
            if (bvalid_ff && s_axi_bready) begin
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    // write decode; upper lanes of byte registers are ignored
    assign wr_go = aw_full_ff && w_full_ff && !bvalid_ff;
    assign wr_ctrl = wr_go && wreq_ff.idx == T2R_IDX_CONTROL;
    assign wr_lo = wr_go && wreq_ff.idx == T2R_IDX_COUNT_LO && wreq_ff.strb[0];
    assign wr_hi = wr_go && wreq_ff.idx == T2R_IDX_COUNT_HI && wreq_ff.strb[0];
    assign wr_irq_req = wr_go && wreq_ff.idx == T2R_IDX_IRQ_REQ;
    assign wr_irq_en = wr_go && wreq_ff.idx == T2R_IDX_IRQ_EN;
    assign wr_reload = wr_go && wreq_ff.idx == T2R_IDX_RELOAD;
    assign wr_sysdiv = wr_go && wreq_ff.idx == T2R_IDX_SYSDIV;
    assign wr_known = wreq_ff.idx inside {T2R_IDX_CONTROL, T2R_IDX_COUNT_LO,
        T2R_IDX_COUNT_HI, T2R_IDX_IRQ_REQ, T2R_IDX_IRQ_EN, T2R_IDX_RELOAD,
        T2R_IDX_SYSDIV};

    // write response, slverr for an unmapped index
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= T2R_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_known ? T2R_RESP_OKAY : T2R_RESP_SLVERR;
        end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= T2R_RST_CONTROL;
            reload_ff <= T2R_RST_RELOAD;
            sysdiv_ff <= T2R_RST_SYSDIV;
            timer_ie_ff <= 1'b0;
            ext_ie_ff <= 1'b0;
        end else begin
            if (wr_ctrl && wreq_ff.strb[0]) begin
                ctrl_ff <= wreq_ff.data[7:0];
            end
            // only the unit 0 reload pair exists here to feed the count
            if (wr_reload && wreq_ff.strb[0]) begin
                reload_ff[7:0] <= wreq_ff.data[7:0];
            end
            if (wr_reload && wreq_ff.strb[1]) begin
                reload_ff[15:8] <= wreq_ff.data[15:8];
            end
            if (wr_sysdiv && wreq_ff.strb[0]) begin
                sysdiv_ff <= wreq_ff.data[7:0];
            end
            if (wr_irq_en && wreq_ff.strb[0]) begin
                timer_ie_ff <= wreq_ff.data[T2R_POS_TIMER_IE];
                ext_ie_ff <= wreq_ff.data[T2R_POS_EXT_IE];
            end
        end
    end

    // system clock divider: one enable every sysdiv+1 aclk cycles
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sdiv_cnt_ff <= 8'h00;
        end else if (sys_en) begin
            sdiv_cnt_ff <= 8'h00;
        end else begin
            sdiv_cnt_ff <= sdiv_cnt_ff + 8'h01;
        end
    end
    // >= so that lowering the divider never strands the counter
    assign sys_en = sdiv_cnt_ff >= sysdiv_ff;

    // timer prescaler on top of the divided system clock
    always_comb begin
        if (ctrl_ff.prescale_bypass_half) begin
            psc_limit = T2R_DIV_HALF;
        end else if (ctrl_ff.prescale_div_select) begin
            psc_limit = T2R_DIV_TWENTYFOUR;
        end else begin
            psc_limit = T2R_DIV_TWELVE;
        end
    end
    assign int_tick = sys_en && psc_cnt_ff >= psc_limit - 5'h01;

    // prescale counter runs freely so the gated mode sees a steady clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            psc_cnt_ff <= 5'h00;
        end else if (int_tick) begin
            psc_cnt_ff <= 5'h00;
        end else if (sys_en) begin
            psc_cnt_ff <= psc_cnt_ff + 5'h01;
        end
    end

    // event input: one sample per machine cycle, edge applied next cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_smp_ff <= 1'b0;
            evt_det_ff <= 1'b0;
        end else if (sys_en) begin
            evt_smp_ff <= external_count_gate_pin;
            evt_det_ff <= evt_smp_ff && !external_count_gate_pin;
        end
    end
    assign evt_tick = sys_en && evt_det_ff;

    // count source selection
    assign in_sel = {ctrl_ff.input_select_hi, ctrl_ff.input_select_lo};
    always_comb begin
        unique case (in_sel)
            T2R_IN_STOP: inc = 1'b0;
            T2R_IN_TIMER: inc = int_tick;
            T2R_IN_EVENT: inc = evt_tick;
            T2R_IN_GATED: inc = int_tick && external_count_gate_pin;
        endcase
    end

    // reload pin falling edge, pin already synchronous to aclk
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            exr_prev_ff <= 1'b1;
        end else begin
            exr_prev_ff <= external_reload_pin;
        end
    end
    assign exr_fall = exr_prev_ff && !external_reload_pin;

    // width, overflow and reload decisions
    assign width8 = ctrl_ff.count_width_select;
    assign rld_mode = {ctrl_ff.reload_mode_hi, ctrl_ff.reload_mode_lo};
    assign ovf = inc && (width8 ? cnt_ff[7:0] == 8'hff
                                : cnt_ff == 16'hffff);
    // in 8-bit width the high byte is left to software
    assign inc_val = width8 ? {cnt_ff[15:8], cnt_ff[7:0] + 8'h01}
                            : cnt_ff + 16'h0001;
    assign rld_ovf = ovf && rld_mode == T2R_RLD_OVF;
    // pin reload ignores the width bit and the enable bit
    assign rld_pin = exr_fall && rld_mode == T2R_RLD_PIN;

    // next count: reload, then increment, then software bytes on top
    always_comb begin
        if (rld_ovf || rld_pin) begin
            nxt_cnt = reload_ff;
        end else if (inc) begin
            nxt_cnt = inc_val;
        end else begin
            nxt_cnt = cnt_ff;
        end
        if (wr_lo) begin
            nxt_cnt[7:0] = wreq_ff.data[7:0];
        end
        if (wr_hi) begin
            nxt_cnt[15:8] = wreq_ff.data[7:0];
        end
    end

    // count register, reachable as two bytes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= T2R_RST_COUNT;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // flags: write one to clear, a same-cycle set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovf_flag_ff <= 1'b0;
            ext_flag_ff <= 1'b0;
        end else begin
            if (ovf) begin
                ovf_flag_ff <= 1'b1;
            end else if (wr_irq_req && wreq_ff.strb[0]
                         && wreq_ff.data[T2R_POS_OVF_FLAG]) begin
                ovf_flag_ff <= 1'b0;
            end
            if (exr_fall && ext_ie_ff) begin
                ext_flag_ff <= 1'b1;
            end else if (wr_irq_req && wreq_ff.strb[0]
                         && wreq_ff.data[T2R_POS_EXT_FLAG]) begin
                ext_flag_ff <= 1'b0;
            end
        end
    end

    // one shared request for both sources, gated by the timer enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_irq_ff <= 1'b0;
        end else begin
            timer_irq_ff <= (ovf_flag_ff || ext_flag_ff)
                            && timer_ie_ff;
        end
    end

    // read mux on the incoming read address
    assign rd_idx = s_axi_araddr[11:2];
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_known = 1'b1;
        unique case (rd_idx)
            T2R_IDX_CONTROL: rd_word[7:0] = ctrl_ff;
            T2R_IDX_COUNT_LO: rd_word[7:0] = cnt_ff[7:0];
            T2R_IDX_COUNT_HI: rd_word[7:0] = cnt_ff[15:8];
            T2R_IDX_IRQ_REQ: begin
                rd_word[T2R_POS_OVF_FLAG] = ovf_flag_ff;
                rd_word[T2R_POS_EXT_FLAG] = ext_flag_ff;
            end
            T2R_IDX_IRQ_EN: begin
                rd_word[T2R_POS_TIMER_IE] = timer_ie_ff;
                rd_word[T2R_POS_EXT_IE] = ext_ie_ff;
            end
            T2R_IDX_RELOAD: rd_word[15:0] = reload_ff;
            T2R_IDX_SYSDIV: rd_word[7:0] = sysdiv_ff;
            default: rd_known = 1'b0;
        endcase
    end

    // read channel: one read in flight, data one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= T2R_RESP_OKAY;
        end else if (s_axi_arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_word;
            rresp_ff <= rd_known ? T2R_RESP_OKAY : T2R_RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
        end
    end

endmodule // t2r_timer

//--- dv/t2r_timer_chk.sv
// port-level assertion checker for the reload timer
`timescale 1ns/1ps
module t2r_timer_chk
    import t2r_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write channels
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read channels
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // timer outputs
    input wire logic [15:0] count_value,
    input wire logic compare_mode_select
);
    // write taken with both halves at one edge, as the bench offers them
    logic wr_go;
    logic [9:0] widx;
    logic [9:0] ridx;
    assign wr_go = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
    assign widx = s_axi_awaddr[11:2];
    assign ridx = s_axi_araddr[11:2];

    // mapped register indices
    function automatic logic mapped(input logic [9:0] i);
        return i inside {T2R_IDX_CONTROL, T2R_IDX_COUNT_LO, T2R_IDX_COUNT_HI,
            T2R_IDX_IRQ_REQ, T2R_IDX_IRQ_EN, T2R_IDX_RELOAD, T2R_IDX_SYSDIV};
    endfunction

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_aw_busy: assert property (
        wr_go |=> !s_axi_awready && !s_axi_wready)
        else $error("readies high");
    chk_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp dropped");
    chk_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata dropped");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("no read answer");
    chk_bad_read: assert property (
        s_axi_arvalid && s_axi_arready && !mapped(ridx)
        |=> s_axi_rresp == T2R_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("bad read kept");
    chk_write_resp: assert property (
        wr_go |-> ##2 s_axi_bvalid && s_axi_bresp ==
        (mapped(widx) ? T2R_RESP_OKAY : T2R_RESP_SLVERR))
        else $error("bresp wrong");
    chk_low_write: assert property (
        wr_go && widx == T2R_IDX_COUNT_LO && s_axi_wstrb[0]
        |-> ##2 count_value[7:0] == $past(s_axi_wdata[7:0], 2))
        else $error("low byte lost");
    chk_high_write: assert property (
        wr_go && widx == T2R_IDX_COUNT_HI && s_axi_wstrb[0]
        |-> ##2 count_value[15:8] == $past(s_axi_wdata[7:0], 2))
        else $error("high byte lost");
    chk_mode_bit: assert property (
        wr_go && widx == T2R_IDX_CONTROL && s_axi_wstrb[0]
        |-> ##2 compare_mode_select == $past(s_axi_wdata[2], 2))
        else $error("mode bit wrong");
endmodule // t2r_timer_chk

bind t2r_timer t2r_timer_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

//--- dv/t2r_pins_model.sv
// pin-side model: event, gate and reload trigger sources
`timescale 1ns/1ps
module t2r_pins_model (
    // clock
    input wire logic aclk,
    // pins toward the timer
    output logic external_count_gate_pin,
    output logic external_reload_pin
);
    // both pins idle high; the reload pin sits on a pull-up
    initial begin
        external_count_gate_pin = 1'b1;
        external_reload_pin = 1'b1;
    end

    // two cycles per level so each machine-cycle sample sees it
    task automatic events(input int n);
        repeat (n) begin
            @(posedge aclk);
            external_count_gate_pin <= 1'b0;
            repeat (2) @(posedge aclk);
            external_count_gate_pin <= 1'b1;
            @(posedge aclk);
        end
    endtask

    // gate level for gated timing
    task automatic gate(input logic v);
        @(posedge aclk);
        external_count_gate_pin <= v;
    endtask

    // one falling edge on the reload trigger
    task automatic pulse_reload();
        @(posedge aclk);
        external_reload_pin <= 1'b0;
        repeat (3) @(posedge aclk);
        external_reload_pin <= 1'b1;
        @(posedge aclk);
    endtask
endmodule // t2r_pins_model

//--- dv/test_t2r_timer.sv
// self-checking bench for the reload timer
`timescale 1ns/1ps
module test_t2r_timer;
    import t2r_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic [2:0] prot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, compare_mode_select, timer_irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [15:0] count_value;
    logic external_count_gate_pin, external_reload_pin;
    int n_fail = 0;
    int checks = 0;

    always #5 aclk = ~aclk;

    t2r_timer #(.ADDR_W(12)) uut (
        .s_axi_awprot(prot), .s_axi_arprot(prot), .*
    );
    t2r_pins_model p (.*);

    task automatic check(input string nm, input logic [31:0] got,
                         input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic hang();
        n_fail++;
        $display("[ERR] wait exp done got hang");
        final_report();
    endtask

    // one write; ready for the answer only once it shows, to test holding
    task automatic wr(input logic [9:0] idx, input logic [31:0] d,
                      input logic [3:0] st = 4'hf,
                      input logic [1:0] er = T2R_RESP_OKAY);
        int n;
        n = 0;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (n > 50) hang();
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
        check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    // one read compared with the expected word and response
    task automatic rchk(input logic [9:0] idx, input logic [31:0] exp,
                        input logic [1:0] er = T2R_RESP_OKAY);
        int n;
        n = 0;
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (n > 50) hang();
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
        check("rdata", s_axi_rdata, exp);
        check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    // cycles until the count next moves
    task automatic wait_change(output int n);
        logic [15:0] prev;
        prev = count_value;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (n > 300) hang();
        end while (count_value === prev);
    endtask

    task automatic wait_count(input logic [15:0] v);
        int n;
        n = 0;
        while (count_value !== v) begin
            @(posedge aclk);
            n++;
            if (n > 300) hang();
        end
    endtask

    // expected clocks per tick from bypass, divide select and divider
    function automatic int period(input logic [7:0] c, input int sd);
        return (sd + 1) * (c[6] ? 2 : (c[7] ? 24 : 12));
    endfunction

    initial begin
        int n;
        int e;
        int sd;
        logic [31:0] r;
        logic [7:0] ctab [4];
        ctab = '{8'h41, 8'h01, 8'h81, 8'hc1};
        void'($urandom(7));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // reset values and refusal of an unmapped index
        rchk(T2R_IDX_CONTROL, 32'h0);
        rchk(T2R_IDX_COUNT_LO, 32'h0);
        rchk(T2R_IDX_COUNT_HI, 32'h0);
        rchk(10'h0e0, 32'h0, T2R_RESP_SLVERR);
        wr(10'h0e0, 32'h5, 4'hf, T2R_RESP_SLVERR);
        // byte registers independent, lane 0 required
        for (int i = 0; i < 4; i++) begin
            r = $urandom;
            wr(T2R_IDX_COUNT_LO, r[7:0]);
            wr(T2R_IDX_COUNT_HI, r[15:8]);
            wr(T2R_IDX_COUNT_LO, ~r, 4'h0);
            rchk(T2R_IDX_COUNT_LO, r[7:0]);
            rchk(T2R_IDX_COUNT_HI, r[15:8]);
        end
        wr(T2R_IDX_CONTROL, 32'h44);
        check("mode bit", compare_mode_select, 1);
        // stopped timer keeps its count
        wr(T2R_IDX_CONTROL, 32'h40);
        repeat (60) @(posedge aclk);
        check("stop", count_value, r[15:0]);
        // every prescale choice against a random system divider
        for (int k = 0; k < 4; k++) begin
            sd = $urandom_range(0, 3);
            wr(T2R_IDX_SYSDIV, sd);
            wr(T2R_IDX_CONTROL, ctab[k]);
            wait_change(n);
            wait_change(n);
            check("period", n, period(ctab[k], sd));
        end
        // event counting of falling pin edges
        wr(T2R_IDX_SYSDIV, 32'h0);
        wr(T2R_IDX_CONTROL, 32'h02);
        wr(T2R_IDX_COUNT_LO, 32'h0);
        wr(T2R_IDX_COUNT_HI, 32'h0);
        e = $urandom_range(3, 9);
        p.events(e);
        repeat (4) @(posedge aclk);
        check("events", count_value, e);
        // gated timing: low gate holds, high gate counts the bypassed clock, once every 2 cycles
        p.gate(1'b0);
        wr(T2R_IDX_CONTROL, 32'h43);
        r = count_value;
        repeat (40) @(posedge aclk);
        check("gate low", count_value, r[15:0]);
        p.gate(1'b1);
        wait_change(n);
        wait_change(n);
        check("gate high", n, 2);
        // 8-bit wrap keeps the high byte and raises the overflow flag
        wr(T2R_IDX_CONTROL, 32'h00);
        wr(T2R_IDX_IRQ_REQ, 32'h3);
        wr(T2R_IDX_COUNT_HI, 32'h12);
        wr(T2R_IDX_COUNT_LO, 32'hf0);
        wr(T2R_IDX_CONTROL, 32'h61);
        wait_count(16'h1200);
        wr(T2R_IDX_CONTROL, 32'h00);
        rchk(T2R_IDX_IRQ_REQ, 32'h1);
        wr(T2R_IDX_IRQ_REQ, 32'h1);
        rchk(T2R_IDX_IRQ_REQ, 32'h0);
        // overflow reload at 16 bits; width bit cleared first
        wr(T2R_IDX_RELOAD, 32'hfff0, 4'h3);
        wr(T2R_IDX_COUNT_HI, 32'hff);
        wr(T2R_IDX_COUNT_LO, 32'hfc);
        wr(T2R_IDX_CONTROL, 32'h51);
        wait_count(16'hfff0);
        wr(T2R_IDX_CONTROL, 32'h00);
        rchk(T2R_IDX_IRQ_REQ, 32'h1);
        wr(T2R_IDX_IRQ_REQ, 32'h1);
        // pin reload at 8-bit width, first without, then with its enable
        r = $urandom;
        wr(T2R_IDX_RELOAD, r, 4'h3);
        wr(T2R_IDX_CONTROL, 32'h38);
        for (int k = 0; k < 2; k++) begin
            wr(T2R_IDX_IRQ_EN, k * 3);
            wr(T2R_IDX_COUNT_LO, 32'h0);
            wr(T2R_IDX_COUNT_HI, 32'h0);
            p.pulse_reload();
            repeat (3) @(posedge aclk);
            check("pin reload", count_value, r[15:0]);
            rchk(T2R_IDX_IRQ_REQ, k * 2);
        end
        check("irq", timer_irq, 1);
        wr(T2R_IDX_IRQ_REQ, 32'h2);
        repeat (3) @(posedge aclk);
        check("irq clear", timer_irq, 0);
        final_report();
    end
endmodule // test_t2r_timer
